/* File: common/dmbd_pkg.sv */
// Package for the data-memory bank decoder and core register group.
// Assumes a single core clock; shared by the decoder, timer and top.
package dmbd_pkg;

    // Widths
    localparam int PC_WIDTH       = 11;
    localparam int LOC_WIDTH      = 7;
    localparam int RAM_WIDTH      = 7;   // 96 + 32 = 128 physical bytes
    localparam int PAGE_WIDTH     = 5;

    // Core register offsets within the special-function region, then RAM and page bounds
    localparam logic [6:0] OFS_INDIRECT  = 7'h00;
    localparam logic [6:0] OFS_TIMER     = 7'h01;
    localparam logic [6:0] OFS_PC_LOW    = 7'h02;
    localparam logic [6:0] OFS_STATUS    = 7'h03;
    localparam logic [6:0] OFS_POINTER   = 7'h04;
    localparam logic [6:0] OFS_PC_HIGH   = 7'h0A;
    localparam logic [6:0] OFS_SFR_TOP   = 7'h1F;
    localparam logic [6:0] OFS_HOLE_A    = 7'h07;
    localparam logic [6:0] OFS_HOLE_B    = 7'h0D;
    localparam logic [6:0] OFS_HOLE_C    = 7'h1D;
    localparam logic [6:0] OFS_HOLE_D    = 7'h1E;
    localparam logic [6:0] OFS_RAM_LO    = 7'h20;
    localparam logic [6:0] OFS_RAM_B1_HI = 7'h3F;
    localparam logic [6:0] OFS_RAM_HI    = 7'h7F;
    localparam logic [6:0] OFS_PAGE3_TOP = 7'h15;

    // Field positions
    localparam int BANK_MSB       = 7;
    localparam int BANK_LSB       = 6;

    // Reset values
    localparam logic [7:0]  RST_PC_LOW   = 8'h00;
    localparam logic [2:0]  RST_PC_HIGH  = 3'h0;
    localparam logic [7:0]  RST_STATUS   = 8'h18;
    localparam logic [7:0]  RST_POINTER  = 8'h00;
    localparam logic [7:0]  RST_TIMER    = 8'h00;

    // Timer clock source
    typedef enum logic [1:0] {
        DMBD_SRC_INSN = 2'b00,
        DMBD_SRC_PIN  = 2'b01,
        DMBD_SRC_LOW  = 2'b10
    } dmbd_src_type;

    // Access kinds from the core
    typedef enum logic [1:0] {
        DMBD_PAGE_R = 2'b00,
        DMBD_PAGE_F = 2'b01,
        DMBD_PAGE_S = 2'b10
    } dmbd_page_type;

    // Sequencing commands for the program counter
    typedef enum logic [1:0] {
        DMBD_PC_HOLD = 2'b00,
        DMBD_PC_STEP = 2'b01,
        DMBD_PC_JUMP = 2'b10,
        DMBD_PC_CALL = 2'b11
    } dmbd_pc_cmd_type;

endpackage : dmbd_pkg

/* File: common/dmbd_timer_if.sv */
// Carrier between the top and the timer-zero counter.
// Assumes one clock domain; the top drives the write side.
`timescale 1ns/100ps
`default_nettype none
interface dmbd_timer_if;
    logic       load;
    logic [7:0] load_data;
    logic [7:0] count;
    modport owner (output load, output load_data, input count);
    modport timer (input load, input load_data, output count);
endinterface : dmbd_timer_if
`default_nettype wire

/* File: verilog/dmbd_timer.sv */
// Timer-zero counter with selectable clock source.
// Assumes source pins are already resynchronised by the top.
`timescale 1ns/100ps
`default_nettype none
module dmbd_timer
    import dmbd_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire dmbd_src_type src_sel,
    input  wire logic         insn_tick,
    input  wire logic         pin_level,
    input  wire logic         low_level,
    dmbd_timer_if.timer       tif
);
    logic src_level;
    logic src_last;
    logic src_rise;
    logic [7:0] count;

    // Pulse sources give ticks; slow sources are edge detected
    assign src_level = (src_sel == DMBD_SRC_PIN) ? pin_level : low_level;
    assign src_rise  = (src_sel == DMBD_SRC_INSN) ? insn_tick : (src_level & ~src_last);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_last <= 1'b0;
        end else begin
            src_last <= src_level;
        end
    end

    // Write wins over a tick in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= RST_TIMER;
        end else if (tif.load) begin
            count <= tif.load_data;
        end else if (src_rise) begin
            count <= count + 8'h01;
        end
    end

    assign tif.count = count;
endmodule : dmbd_timer
`default_nettype wire

/* File: verilog/dmbd_ram.sv */
// General-purpose RAM held in flip-flops, one byte per physical cell.
// Assumes the decoder hands it a resolved physical index.
`timescale 1ns/100ps
`default_nettype none
module dmbd_ram
    import dmbd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 wr_en,
    input  wire logic [RAM_WIDTH-1:0] index,
    input  wire logic [7:0]           wr_data,
    output logic [7:0]                rd_data
);
    logic [7:0] cells [0:(1<<RAM_WIDTH)-1];

    // Contents are undefined after reset, as in the real array
    always_ff @(posedge clk) begin
        if (wr_en) begin
            cells[index] <= wr_data;
        end
    end

    assign rd_data = cells[index];
endmodule : dmbd_ram
`default_nettype wire

/* File: verilog/dmbd_core.sv */
// Data-memory bank decoder with the core register group.
// Assumes the core presents one access per cycle with a same-cycle read.
//
// Summary of operation
// - Bank 1-3 low region maps to bank 0
// - RAM only at bank0 20-7F, bank1 20-3F
// - Upper banks alias bank 0 or 1
// - Status top bits select one of four banks
// - Indirect uses selector plus pointer low bits
// - Direct uses selector plus opcode low bits
// - Bank 0 low region distinct registers
// - Second page only via its instruction pair
// - Third page via own pair, 0 to 15h
// - Selector ignored for second and third pages
// - Indirect port redirects through pointer
// - Timer read returns live count
// - Timer write replaces count at once
// - Timer clock from three selectable sources
// - Counter low byte visible, resets zero
// - Counter steps by one per instruction
// - Upper counter bits on a data write only via high buffer
// - Long jump loads all eleven bits
// - Long call loads bits, pushes next address
`timescale 1ns/100ps
`default_nettype none
module dmbd_core
    import dmbd_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Data-memory access from the core
    input  wire dmbd_page_type   acc_page,
    input  wire logic [6:0]      acc_addr,
    input  wire logic            acc_rd,
    input  wire logic            acc_wr,
    input  wire logic [7:0]      acc_wdata,
    output logic [7:0]           acc_rdata,
    // Outside special-function registers and pages
    output logic                 acc_ext_sel,
    output logic [6:0]           acc_ext_addr,
    input  wire logic [7:0]      acc_ext_rdata,
    // Program sequencing
    input  wire dmbd_pc_cmd_type pc_cmd,
    input  wire logic [10:0]     pc_target,
    output logic [10:0]          pc,
    output logic                 push_en,
    output logic [10:0]          push_addr,
    // Timer-zero clock sources, then the bank selector output
    input  wire dmbd_src_type    timer_src,
    input  wire logic            instruction_clock,
    input  wire logic            external_timer_clock_pin,
    input  wire logic            low_osc_clock,
    output logic [1:0]           bank_selector
);
    ////////////////////////////////////////////////////////////////////////////
    // Core registers
    logic [7:0]  status;
    logic [7:0]  file_select_pointer;
    logic [2:0]  program_counter_high_buffer;
    logic [10:0] pc_reg;

    // Timing seen by the core:
    //   one access per cycle, back to back allowed
    //   read data follows the address within the same cycle
    //   writes land at the clock edge that samples the strobe
    //   a low-byte counter write beats the sequencing command
    //   and suppresses the stack push of a call in that cycle
    //   general-purpose cells are not cleared by reset
    //   a pointer aimed back at the indirect port reads zero
    // Pages F and S live outside; only the resolved select and
    // location leave this block, and their data comes back unlatched.
    // Limitation: the read path is fully combinational, so the
    // core must allow the decode and mux delay within its cycle.

    ////////////////////////////////////////////////////////////////////////////
    // Decode functions
    function automatic logic is_hole(input logic [6:0] loc);
        is_hole = (loc == OFS_HOLE_A) || (loc == OFS_HOLE_B)
               || (loc == OFS_HOLE_C) || (loc == OFS_HOLE_D);
    endfunction : is_hole

    // One special-function slot of the low region, bank ignored
    function automatic logic sfr_slot(input logic       in_region,
                                      input logic [6:0] at,
                                      input logic [6:0] slot);
        sfr_slot = in_region && (at == slot);
    endfunction : sfr_slot

    // Physical layout of the 128-cell array:
    //   cells 00-5F hold bank 0 locations 20-7F
    //   cells 60-7F hold bank 1 locations 20-3F
    // Bank 2 has no cells of its own and folds wholly onto bank 0.
    // Bank 3 folds like bank 1, so only selector bit 0 matters here.
    // Upper locations 40-7F of banks 1 and 3 fall back to bank 0.

    // Fold bank and location onto a physical RAM index
    function automatic logic [RAM_WIDTH-1:0] ram_index(input logic [1:0] bank,
                                                       input logic [6:0] loc);
        logic b1;
        b1 = bank[0] && (loc <= OFS_RAM_B1_HI);
        if (b1) begin
            ram_index = {2'b11, loc[4:0]};
        end else begin
            ram_index = loc - OFS_RAM_LO;
        end
    endfunction : ram_index

    ////////////////////////////////////////////////////////////////////////////
    // Address resolution
    wire logic       is_r_page;
    wire logic       is_indirect;
    wire logic [6:0] loc;
    wire logic       is_sfr;
    wire logic       is_ram;

    // Register hits
    wire logic       hit_hole;
    wire logic       hit_timer;
    wire logic       hit_pc_low;
    wire logic       hit_status;
    wire logic       hit_pointer;
    wire logic       hit_pc_high;
    wire logic       hit_ext;
    wire logic       page3_ok;

    // RAM and timer links, page decodes, core and peripheral hits
    wire logic [RAM_WIDTH-1:0] ram_idx;
    wire logic [7:0] ram_rdata;
    wire logic       ram_wr;
    wire logic [7:0] timer_count;
    wire logic       is_f_page;
    wire logic       is_s_page;
    wire logic       hit_core;
    wire logic       hit_periph;

    assign bank_selector = status[BANK_MSB:BANK_LSB];
    assign is_r_page   = (acc_page == DMBD_PAGE_R);
    assign is_indirect = is_r_page && (acc_addr == OFS_INDIRECT);
    // Pointer low bits when indirect, opcode bits when direct
    assign loc = is_indirect ? file_select_pointer[6:0]
                             : acc_addr;
    // Low region ignores bank: one physical copy
    assign is_sfr = is_r_page && (loc <= OFS_SFR_TOP);
    assign is_ram = is_r_page && (loc >= OFS_RAM_LO);
    assign ram_idx = ram_index(bank_selector, loc);

    // A pointer aimed back at the port reads zero, avoiding a loop
    assign hit_hole    = is_sfr && (is_hole(loc) || loc == OFS_INDIRECT);
    assign hit_timer   = sfr_slot(is_sfr, loc, OFS_TIMER);
    assign hit_pc_low  = sfr_slot(is_sfr, loc, OFS_PC_LOW);
    assign hit_status  = sfr_slot(is_sfr, loc, OFS_STATUS);
    assign hit_pointer = sfr_slot(is_sfr, loc, OFS_POINTER);
    assign hit_pc_high = sfr_slot(is_sfr, loc, OFS_PC_HIGH);

    // Pages F and S never see the bank selector
    assign is_f_page   = (acc_page == DMBD_PAGE_F);
    assign is_s_page   = (acc_page == DMBD_PAGE_S);
    assign page3_ok    = is_s_page && (acc_addr <= OFS_PAGE3_TOP);

    // Low-region slots served here; every other one goes outside
    assign hit_core   = hit_hole || hit_timer || hit_pc_low
                     || hit_status || hit_pointer || hit_pc_high;
    assign hit_periph = is_sfr && !hit_core;

    // Pages F and S only through their own instructions
    assign hit_ext = hit_periph
                  || is_f_page
                  || page3_ok;
    assign acc_ext_sel  = hit_ext && (acc_rd || acc_wr);
    assign acc_ext_addr = is_r_page ? loc : acc_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        if (hit_timer) begin
            acc_rdata = timer_count;
        end else if (hit_pc_low) begin
            acc_rdata = pc_reg[7:0];
        end else if (hit_status) begin
            acc_rdata = status;
        end else if (hit_pointer) begin
            acc_rdata = file_select_pointer;
        end else if (hit_pc_high) begin
            acc_rdata = 8'h00;
        end else if (is_ram) begin
            acc_rdata = ram_rdata;
        end else if (hit_ext) begin
            acc_rdata = acc_ext_rdata;
        end else begin
            acc_rdata = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RAM and timer
    assign ram_wr = acc_wr && is_ram;

    dmbd_ram u_ram (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (ram_wr),
        .index   (ram_idx),
        .wr_data (acc_wdata),
        .rd_data (ram_rdata)
    );

    // Pin and oscillator inputs: three stages, change once 2nd and 3rd agree
    logic [2:0] pin_sync;
    logic [2:0] osc_sync;
    logic       pin_clean;
    logic       osc_clean;
    wire logic  pin_agree;
    wire logic  osc_agree;

    // Stage three must confirm stage two before a level is taken
    assign pin_agree = (pin_sync[2] == pin_sync[1]);
    assign osc_agree = (osc_sync[2] == osc_sync[1]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_sync <= 3'h0;
            osc_sync <= 3'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], external_timer_clock_pin};
            osc_sync <= {osc_sync[1:0], low_osc_clock};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_clean <= 1'b0;
            osc_clean <= 1'b0;
        end else begin
            if (pin_agree) begin
                pin_clean <= pin_sync[2];
            end
            if (osc_agree) begin
                osc_clean <= osc_sync[2];
            end
        end
    end

    dmbd_timer_if tif ();
    assign tif.load      = acc_wr && hit_timer;
    assign tif.load_data = acc_wdata;
    assign timer_count   = tif.count;

    dmbd_timer u_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .src_sel   (timer_src),
        .insn_tick (instruction_clock),
        .pin_level (pin_clean),
        .low_level (osc_clean),
        .tif       (tif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status, pointer and high buffer
    // Write strobes decoded once; each register keeps its own short process
    wire logic status_wr;
    wire logic pointer_wr;
    wire logic high_wr;
    assign status_wr  = acc_wr && hit_status;
    assign pointer_wr = acc_wr && hit_pointer;
    assign high_wr    = acc_wr && hit_pc_high;

    // Bank selector lives in the top two status bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= RST_STATUS;
        end else if (status_wr) begin
            status <= acc_wdata;
        end
    end

    // Bit 7 is stored but never used for addressing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            file_select_pointer <= RST_POINTER;
        end else if (pointer_wr) begin
            file_select_pointer <= acc_wdata;
        end
    end

    // Write-only: reads of this offset return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            program_counter_high_buffer <= RST_PC_HIGH;
        end else if (high_wr) begin
            program_counter_high_buffer <= acc_wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter; a data write to the low byte beats sequencing
    wire logic [10:0] next_pc;
    wire logic        pc_low_wr;
    wire logic [10:0] pc_following;
    wire logic [10:0] pc_written;
    wire logic        pc_loads;
    // One adder serves both stepping and the call return address
    assign pc_following = pc_reg + 11'h001;
    // Upper bits of a low-byte data write only ever come from the high buffer
    assign pc_written   = {program_counter_high_buffer, acc_wdata};
    assign pc_loads     = (pc_cmd == DMBD_PC_JUMP) || (pc_cmd == DMBD_PC_CALL);
    assign pc_low_wr    = acc_wr && hit_pc_low;
    assign next_pc = pc_low_wr ? pc_written
                   : pc_loads ? pc_target
                   : (pc_cmd == DMBD_PC_STEP) ? pc_following
                   : pc_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_reg <= {RST_PC_HIGH, RST_PC_LOW};
        end else begin
            pc_reg <= next_pc;
        end
    end

    // Return address is the one after the call
    assign push_en   = (pc_cmd == DMBD_PC_CALL) && !pc_low_wr;
    assign push_addr = pc_following;
    assign pc        = pc_reg;
endmodule : dmbd_core
`default_nettype wire

/* File: bench/dmbd_periph_model.sv */
// Far-side peripheral model answering outside-page reads.
// Assumes the decoder drives select and resolved address combinationally.
`timescale 1ns/100ps
`default_nettype none
module dmbd_periph_model (
    input  wire logic       clk,
    input  wire logic       acc_ext_sel,
    input  wire logic [6:0] acc_ext_addr,
    output logic [7:0]      acc_ext_rdata
);
    logic [7:0] last;

    // Unselected bus shows the inverse, so a stale byte never passes
    assign acc_ext_rdata = acc_ext_sel ? {1'b1, acc_ext_addr} : ~last;
    always_ff @(posedge clk) begin
        last <= acc_ext_rdata;
    end
endmodule : dmbd_periph_model
`default_nettype wire

/* File: bench/dmbd_core_asserts.sv */
// Port-level checker for the bank decoder and program counter.
// Assumes it is bound onto the top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dmbd_core_asserts
    import dmbd_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_n,
    input wire dmbd_page_type   acc_page,
    input wire logic [6:0]      acc_addr,
    input wire logic            acc_rd,
    input wire logic            acc_wr,
    input wire logic [7:0]      acc_wdata,
    input wire logic [7:0]      acc_rdata,
    input wire logic            acc_ext_sel,
    input wire logic [6:0]      acc_ext_addr,
    input wire dmbd_pc_cmd_type pc_cmd,
    input wire logic [10:0]     pc_target,
    input wire logic [10:0]     pc,
    input wire logic            push_en,
    input wire logic [10:0]     push_addr,
    input wire logic [1:0]      bank_selector
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Decoded helpers; a low-byte write overrides sequencing
    wire       r_pg   = acc_page == DMBD_PAGE_R;
    wire       pcl_wr = acc_wr && r_pg && acc_addr == OFS_PC_LOW;
    wire [1:0] wr_bk  = acc_wdata[7:6];
    wire       hole   = acc_addr == OFS_HOLE_A || acc_addr == OFS_HOLE_B
                     || acc_addr == OFS_HOLE_C || acc_addr == OFS_HOLE_D;

    ////////////////////////////////////////////////////////////////////
    reset_pc_a: assert property ($rose(rst_n) |-> pc == 11'h000)
        else $error("pc not zero after reset");
    step_pc_a: assert property (pc_cmd == DMBD_PC_STEP && !pcl_wr |=> pc == $past(pc) + 11'h001)
        else $error("pc did not step by one");
    hold_pc_a: assert property (pc_cmd == DMBD_PC_HOLD && !pcl_wr |=> $stable(pc))
        else $error("pc moved while held");
    jump_pc_a: assert property (pc_cmd == DMBD_PC_JUMP && !pcl_wr |=> pc == $past(pc_target))
        else $error("jump target not loaded");
    call_push_a: assert property (pc_cmd == DMBD_PC_CALL && !pcl_wr |-> push_en && push_addr == pc + 11'h001 ##1 pc == $past(pc_target))
        else $error("call push or load wrong");
    bank_sel_a: assert property (acc_wr && r_pg && acc_addr == OFS_STATUS |=> bank_selector == $past(wr_bk))
        else $error("bank selector not written");
    hole_zero_a: assert property (r_pg && hole |-> acc_rdata == 8'h00)
        else $error("unimplemented address read nonzero");
    s_top_a: assert property (acc_page == DMBD_PAGE_S && acc_addr > OFS_PAGE3_TOP |-> acc_rdata == 8'h00)
        else $error("third page beyond top read nonzero");
    f_page_a: assert property (acc_page == DMBD_PAGE_F && acc_rd |-> acc_ext_sel && acc_ext_addr == acc_addr)
        else $error("second page not steered outside");
endmodule : dmbd_core_asserts
bind dmbd_core dmbd_core_asserts u_chk (.*);
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the bank decoder and core registers.
// Assumes a 50 MHz clock; the peripheral model answers outside pages.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dmbd_pkg::*;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    dmbd_page_type   acc_page = DMBD_PAGE_R;
    logic [6:0]      acc_addr = 7'h00;
    logic            acc_rd = 1'b0;
    logic            acc_wr = 1'b0;
    logic [7:0]      acc_wdata = 8'h00;
    logic [7:0]      acc_rdata;
    logic            acc_ext_sel;
    logic [6:0]      acc_ext_addr;
    logic [7:0]      acc_ext_rdata;
    dmbd_pc_cmd_type pc_cmd = DMBD_PC_HOLD;
    logic [10:0]     pc_target = 11'h000;
    logic [10:0]     pc;
    logic            push_en;
    logic [10:0]     push_addr;
    dmbd_src_type    timer_src = DMBD_SRC_INSN;
    logic            insn_clk = 1'b0;
    logic            ext_pin = 1'b0;
    logic            low_osc = 1'b0;
    logic [1:0]      bank_selector;
    int              mismatches = 0;
    int              n_checks = 0;
    logic [6:0]      holes [4] = '{7'h07, 7'h0D, 7'h1D, 7'h1E};

    dmbd_core u_dut (.clk(clk), .rst_n(rst_n), .acc_page(acc_page), .acc_addr(acc_addr),
        .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_ext_sel(acc_ext_sel), .acc_ext_addr(acc_ext_addr), .acc_ext_rdata(acc_ext_rdata),
        .pc_cmd(pc_cmd), .pc_target(pc_target), .pc(pc), .push_en(push_en),
        .push_addr(push_addr), .timer_src(timer_src), .instruction_clock(insn_clk),
        .external_timer_clock_pin(ext_pin), .low_osc_clock(low_osc),
        .bank_selector(bank_selector));
    dmbd_periph_model u_periph (.clk(clk), .acc_ext_sel(acc_ext_sel),
        .acc_ext_addr(acc_ext_addr), .acc_ext_rdata(acc_ext_rdata));

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Inputs move 2 ns after the edge, clear of sampling
    task automatic wr(input dmbd_page_type pg, input logic [6:0] a, input logic [7:0] d);
        acc_page = pg;
        acc_addr = a;
        acc_wdata = d;
        acc_wr = 1'b1;
        @(posedge clk) #2;
        acc_wr = 1'b0;
        // Idle edge, so a following write never re-raises in this step
        @(posedge clk) #2;
    endtask : wr

    // Read data is combinational, so it is judged mid-cycle
    task automatic rd(input dmbd_page_type pg, input logic [6:0] a, input logic [7:0] e);
        acc_page = pg;
        acc_addr = a;
        acc_rd = 1'b1;
        @(negedge clk);
        chk({3'h0, acc_rdata}, {3'h0, e});
        @(posedge clk) #2;
        acc_rd = 1'b0;
        // Idle edge, so a following read never re-raises in this step
        @(posedge clk) #2;
    endtask : rd

    task automatic bank(input logic [1:0] b);
        wr(DMBD_PAGE_R, OFS_STATUS, {b, 6'h18});
    endtask : bank

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc

    ////////////////////////////////////////////////////////////////////
    task automatic t_banks;
        chk(pc, 11'h000);
        for (int b = 0; b < 4; b++) begin
            bank(b[1:0]);
            chk({9'h0, bank_selector}, b[10:0]);
        end
        bank(2'h0);
        wr(DMBD_PAGE_R, 7'h25, 8'hA0);
        wr(DMBD_PAGE_R, 7'h45, 8'hB0);
        bank(2'h1);
        wr(DMBD_PAGE_R, 7'h25, 8'hA1);
        // Odd banks see the bank one copy of the low RAM range
        for (int b = 0; b < 4; b++) begin
            bank(b[1:0]);
            rd(DMBD_PAGE_R, 7'h25, b[0] ? 8'hA1 : 8'hA0);
            rd(DMBD_PAGE_R, 7'h45, 8'hB0);
        end
    endtask : t_banks

    task automatic t_sfr;
        bank(2'h3);
        wr(DMBD_PAGE_R, OFS_POINTER, 8'h25);
        bank(2'h1);
        rd(DMBD_PAGE_R, OFS_POINTER, 8'h25);
        rd(DMBD_PAGE_R, OFS_INDIRECT, 8'hA1);
        wr(DMBD_PAGE_R, OFS_INDIRECT, 8'hC1);
        rd(DMBD_PAGE_R, 7'h25, 8'hC1);
        // Pointer bit 7 set: only its low bits may reach the outside
        wr(DMBD_PAGE_R, OFS_POINTER, 8'h85);
        rd(DMBD_PAGE_R, OFS_INDIRECT, 8'h85);
        foreach (holes[i]) begin
            wr(DMBD_PAGE_R, holes[i], 8'hFF);
            rd(DMBD_PAGE_R, holes[i], 8'h00);
        end
    endtask : t_sfr

    task automatic t_pages;
        bank(2'h3);
        rd(DMBD_PAGE_F, 7'h05, 8'h85);
        rd(DMBD_PAGE_S, OFS_PAGE3_TOP, 8'h95);
        rd(DMBD_PAGE_S, 7'h16, 8'h00);
    endtask : t_pages

    task automatic t_timer;
        wr(DMBD_PAGE_R, OFS_TIMER, 8'hFE);
        rd(DMBD_PAGE_R, OFS_TIMER, 8'hFE);
        insn_clk = 1'b1;
        cyc(3);
        insn_clk = 1'b0;
        rd(DMBD_PAGE_R, OFS_TIMER, 8'h01);
        // Slow pulses leave room for the input synchronisers
        timer_src = DMBD_SRC_PIN;
        wr(DMBD_PAGE_R, OFS_TIMER, 8'h40);
        repeat (2) begin
            ext_pin = 1'b1;
            cyc(8);
            ext_pin = 1'b0;
            cyc(8);
        end
        rd(DMBD_PAGE_R, OFS_TIMER, 8'h42);
        timer_src = DMBD_SRC_LOW;
        low_osc = 1'b1;
        cyc(8);
        low_osc = 1'b0;
        cyc(8);
        rd(DMBD_PAGE_R, OFS_TIMER, 8'h43);
    endtask : t_timer

    task automatic t_pc;
        pc_cmd = DMBD_PC_JUMP;
        pc_target = 11'h5A3;
        cyc(1);
        pc_cmd = DMBD_PC_STEP;
        cyc(4);
        pc_cmd = DMBD_PC_HOLD;
        chk(pc, 11'h5A7);
        rd(DMBD_PAGE_R, OFS_PC_LOW, 8'hA7);
        pc_cmd = DMBD_PC_CALL;
        pc_target = 11'h123;
        @(negedge clk);
        chk({10'h0, push_en}, 11'h001);
        chk(push_addr, 11'h5A8);
        cyc(1);
        pc_cmd = DMBD_PC_HOLD;
        chk(pc, 11'h123);
        wr(DMBD_PAGE_R, OFS_PC_HIGH, 8'h05);
        wr(DMBD_PAGE_R, OFS_PC_LOW, 8'h34);
        chk(pc, 11'h534);
        rd(DMBD_PAGE_R, OFS_PC_HIGH, 8'h00);
    endtask : t_pc

    task automatic summarize;
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    initial begin
        cyc(20);
        rst_n = 1'b1;
        t_banks();
        t_sfr();
        t_pages();
        t_timer();
        t_pc();
        summarize();
    end
endmodule : tb
`default_nettype wire
